// *** hdl/dfxd_pkg.sv ***
// Constants and types of the decorated field extract bridge.
// Assumes a 32-bit AHB-Lite style bus on both sides.
package dfxd_pkg;
	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [31:0] PERI_BASE = 32'h4000_0000;
	localparam logic [5:0] UNDEC_TOP = 6'h10;
	localparam logic [5:0] UNDEC_MEG = 6'h00;
	localparam logic [3:0] LOGIC_NIB = 4'h4;
	localparam logic [1:0] PERI_SEL = 2'h2;
	localparam logic [7:0] GPIO_STD_PAGE = 8'hFF;
	localparam logic [7:0] GPIO_PHYS_PAGE = 8'h0F;
	localparam int SLOT_KB = 4;
	localparam int NUM_SLOTS = 129;
	// ----------------------------------------------------------------
	// Decoration fields
	// ----------------------------------------------------------------
	localparam int LSB_HI = 27;
	localparam int LSB_LO = 23;
	localparam int WID_HI = 22;
	localparam int WID_LO = 19;
	localparam int EXT_OFS_HI = 18;
	localparam int LOG_OFS_HI = 19;
	localparam int GPIO_PG_LO = 12;
	// ----------------------------------------------------------------
	// Bus encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] TRANS_IDLE = 2'h0;
	localparam logic [1:0] TRANS_NONSEQ = 2'h2;
	localparam logic [2:0] SIZE_BYTE = 3'h0;
	localparam logic [2:0] SIZE_HALF = 3'h1;
	localparam logic [2:0] SIZE_WORD = 3'h2;
	localparam logic [31:0] MASK_BYTE = 32'h0000_00FF;
	localparam logic [31:0] MASK_HALF = 32'h0000_FFFF;
	localparam logic [31:0] MASK_WORD = 32'hFFFF_FFFF;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_EXT_DP1,
		ST_EXT_DP2,
		ST_ERR1,
		ST_ERR2
	} dfxd_phase_type;

	typedef enum logic [1:0] {
		K_NORMAL,
		K_DECOR,
		K_EXTRACT,
		K_ILLEGAL
	} dfxd_kind_type;
endpackage

// *** hdl/dfxd_bridge.sv ***
// Decorated peripheral address decoder with unsigned field extract engine.
// Assumes one upstream master, one downstream slave space, zero-wait idle replies.
//
// Operation
// - Extract returns field of width code plus one, right-justified, upper bits zero.
// - Extract only reads; it never issues a write downstream.
// - Container size follows transfer size: byte, halfword or word.
// - Word extracts return at most sixteen bits.
// - Extract recognised when addr[30:29] is 10 and addr[28] is set.
// - LSB position from addr[27:23], width code from addr[22:19].
// - Real address is peripheral base plus addr[18:0].
// - Field running past container top keeps only bits up to container top.
// - First cycle forwards undecorated address and captures attributes.
// - Second cycle drives an idle address phase downstream.
// - First data phase masks read data and registers it.
// - Third cycle shifts registered data right and returns it.
// - Undecorated 0x4000_0000..0x4007_FFFF pass through normally.
// - GPIO at 0x400F_F000 page is aliased to physical 0x4000_F000 slot.
// - Illegal peripheral ranges are aborted with an error response.
// - 0x44..0x4F carries logical and load-modify ops, either GPIO base.
// - Field ops from 0x5000_0000; master uses the 0x4000_F000 GPIO alias.
// - Bit 19 is address for logical ops, width LSB for field ops.
// - Peripheral space is 512 KB plus 4 KB GPIO, 129 slots.
// - Downstream wait states pass straight back to the master.
// - Master stalled during the extract's first data phase.
`timescale 1ns/1ns
`default_nettype none
module dfxd_bridge #(
	parameter int DATA_W = 32
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Upstream port from the master
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [DATA_W-1:0] hwdata,
	input wire logic hreadyIn,
	output logic [DATA_W-1:0] hrdata,
	output logic hreadyOut,
	output logic hresp,
	// Downstream port to the peripheral space
	output logic [31:0] mHaddr,
	output logic [1:0] mHtrans,
	output logic mHwrite,
	output logic [2:0] mHsize,
	output logic [DATA_W-1:0] mHwdata,
	input wire logic [DATA_W-1:0] mHrdata,
	input wire logic mHready,
	input wire logic mHresp
);
	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (DATA_W != 32) begin : g_bad_width
		$error("dfxd_bridge serves a 32-bit data path only");
	end
	if (dfxd_pkg::NUM_SLOTS * dfxd_pkg::SLOT_KB != 516) begin : g_bad_map
		$error("dfxd_bridge slot map inconsistent");
	end

	typedef struct packed {
		dfxd_pkg::dfxd_phase_type phase;
		logic passDp;
		logic [4:0] lsb;
		logic [3:0] wcode;
		logic [2:0] size;
		logic [1:0] lane;
		logic [31:0] data;
	} dfxd_regs_type;

	dfxd_regs_type s_r;
	dfxd_regs_type s_nxt;
	dfxd_pkg::dfxd_kind_type reqKind;
	logic canTake;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	// 512 KB peripheral block or the 4 KB GPIO page; the rest is a hole
	function automatic logic legalOfs(input logic [19:0] ofs);
		legalOfs = !ofs[dfxd_pkg::LOG_OFS_HI]
			|| (ofs[dfxd_pkg::LOG_OFS_HI:dfxd_pkg::GPIO_PG_LO] == dfxd_pkg::GPIO_STD_PAGE);
	endfunction

	function automatic dfxd_pkg::dfxd_kind_type decodeKind(input logic [31:0] a,
		input logic wr, input logic [2:0] sz);
		decodeKind = dfxd_pkg::K_ILLEGAL;
		if (!a[31] && a[30:29] == dfxd_pkg::PERI_SEL && a[28]) begin
			if (wr) begin
				decodeKind = dfxd_pkg::K_DECOR;
			end else if (sz <= dfxd_pkg::SIZE_WORD) begin
				decodeKind = dfxd_pkg::K_EXTRACT;
			end
		end else if (a[31:26] == dfxd_pkg::UNDEC_TOP) begin
			if (a[25:20] == dfxd_pkg::UNDEC_MEG && legalOfs(a[19:0])) begin
				decodeKind = dfxd_pkg::K_NORMAL;
			end
		end else if (a[31:28] == dfxd_pkg::LOGIC_NIB) begin
			// Bit 19 is a real address bit here
			if (legalOfs(a[dfxd_pkg::LOG_OFS_HI:0])) begin
				decodeKind = dfxd_pkg::K_DECOR;
			end
		end
	endfunction

	function automatic logic [31:0] physAddr(input logic [19:0] ofs);
		physAddr = {dfxd_pkg::PERI_BASE[31:20], ofs};
		if (ofs[dfxd_pkg::LOG_OFS_HI:dfxd_pkg::GPIO_PG_LO] == dfxd_pkg::GPIO_STD_PAGE) begin
			physAddr = {dfxd_pkg::PERI_BASE[31:20], dfxd_pkg::GPIO_PHYS_PAGE,
				ofs[dfxd_pkg::GPIO_PG_LO-1:0]};
		end
	endfunction

	// Container-local field, masked to both the field and the container
	function automatic logic [31:0] maskField(input logic [31:0] rd, input logic [2:0] sz,
		input logic [1:0] lane, input logic [4:0] lsb, input logic [3:0] wc);
		logic [31:0] cont;
		logic [31:0] contMask;
		logic [31:0] fieldMask;
		cont = rd >> {lane, 3'h0};
		case (sz)
			dfxd_pkg::SIZE_BYTE: contMask = dfxd_pkg::MASK_BYTE;
			dfxd_pkg::SIZE_HALF: contMask = dfxd_pkg::MASK_HALF;
			default: contMask = dfxd_pkg::MASK_WORD;
		endcase
		// Four-bit code caps the field at sixteen bits
		fieldMask = ~(dfxd_pkg::MASK_WORD << ({1'b0, wc} + 5'h01));
		fieldMask = fieldMask << lsb;
		maskField = cont & contMask & fieldMask;
	endfunction

	assign reqKind = decodeKind(haddr, hwrite, hsize);
	assign canTake = hsel && htrans[1] && hreadyIn
		&& s_r.phase != dfxd_pkg::ST_EXT_DP1 && s_r.phase != dfxd_pkg::ST_ERR1;

	// ----------------------------------------------------------------
	// Next state and bus drive
	// ----------------------------------------------------------------
	// Address phase is forwarded combinationally so the extract keeps its three-cycle
	// shape; a registered address would add a cycle to every access.
	always_comb begin
		s_nxt = s_r;
		mHaddr = haddr;
		mHtrans = dfxd_pkg::TRANS_IDLE;
		mHwrite = hwrite;
		mHsize = hsize;
		mHwdata = hwdata;
		hreadyOut = 1'b1;
		hresp = 1'b0;
		hrdata = mHrdata;
		if (s_r.passDp && mHready) begin
			s_nxt.passDp = 1'b0;
		end
		case (s_r.phase)
			dfxd_pkg::ST_IDLE: begin
				if (s_r.passDp) begin
					hreadyOut = mHready;
					hresp = mHresp;
				end
			end
			dfxd_pkg::ST_EXT_DP1: begin
				hreadyOut = 1'b0;
				if (mHready) begin
					if (mHresp) begin
						s_nxt.phase = dfxd_pkg::ST_ERR1;
					end else begin
						s_nxt.data = maskField(mHrdata, s_r.size, s_r.lane, s_r.lsb, s_r.wcode);
						s_nxt.phase = dfxd_pkg::ST_EXT_DP2;
					end
				end
			end
			dfxd_pkg::ST_EXT_DP2: begin
				hrdata = (s_r.data >> s_r.lsb) << {s_r.lane, 3'h0};
				s_nxt.phase = dfxd_pkg::ST_IDLE;
			end
			dfxd_pkg::ST_ERR1: begin
				hreadyOut = 1'b0;
				hresp = 1'b1;
				s_nxt.phase = dfxd_pkg::ST_ERR2;
			end
			dfxd_pkg::ST_ERR2: begin
				hresp = 1'b1;
				s_nxt.phase = dfxd_pkg::ST_IDLE;
			end
			default: begin
				s_nxt.phase = dfxd_pkg::ST_IDLE;
			end
		endcase
		if (canTake) begin
			case (reqKind)
				dfxd_pkg::K_EXTRACT: begin
					mHaddr = {dfxd_pkg::PERI_BASE[31:19], haddr[dfxd_pkg::EXT_OFS_HI:0]};
					mHtrans = dfxd_pkg::TRANS_NONSEQ;
					mHwrite = 1'b0;
					s_nxt.lsb = haddr[dfxd_pkg::LSB_HI:dfxd_pkg::LSB_LO];
					s_nxt.wcode = haddr[dfxd_pkg::WID_HI:dfxd_pkg::WID_LO];
					s_nxt.size = hsize;
					s_nxt.lane = haddr[1:0];
					s_nxt.phase = dfxd_pkg::ST_EXT_DP1;
				end
				dfxd_pkg::K_NORMAL: begin
					mHaddr = physAddr(haddr[19:0]);
					mHtrans = htrans;
					s_nxt.passDp = 1'b1;
				end
				dfxd_pkg::K_DECOR: begin
					// Decoration kept intact for the store-side engine
					mHtrans = htrans;
					s_nxt.passDp = 1'b1;
				end
				default: begin
					s_nxt.phase = dfxd_pkg::ST_ERR1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '{phase: dfxd_pkg::ST_IDLE, passDp: 1'b0, lsb: 5'h00, wcode: 4'h0,
				size: 3'h0, lane: 2'h0, data: 32'h0000_0000};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	logic takeExt;
	logic takeBad;
	logic takeNorm;
	assign takeExt = canTake && reqKind == dfxd_pkg::K_EXTRACT;
	assign takeBad = canTake && reqKind == dfxd_pkg::K_ILLEGAL;
	assign takeNorm = canTake && reqKind == dfxd_pkg::K_NORMAL;

	a_ext_read_only: assert property (takeExt |-> mHtrans[1] && !mHwrite ##1 !mHtrans[1])
		else $error("extract issued a write or no read");
	a_ext_real_addr: assert property (takeExt |-> mHaddr[31:19] == 13'h0800
		&& mHaddr[18:0] == haddr[18:0])
		else $error("extract address not undecorated");
	a_ext_idle_second: assert property (takeExt |=> mHtrans == 2'h0)
		else $error("second extract cycle not idle");
	a_ext_stall_dp1: assert property (s_r.phase == dfxd_pkg::ST_EXT_DP1 |-> !hreadyOut)
		else $error("master not stalled in first data phase");
	a_ext_return: assert property (s_r.phase == dfxd_pkg::ST_EXT_DP1 && mHready && !mHresp
		|=> hreadyOut && !hresp ##1 s_r.phase != dfxd_pkg::ST_EXT_DP2)
		else $error("extract result not returned next cycle");
	a_word_width: assert property (s_r.phase == dfxd_pkg::ST_EXT_DP2
		&& s_r.size == dfxd_pkg::SIZE_WORD |-> hrdata[31:16] == 16'h0000
		&& (hrdata >> ({1'b0, s_r.wcode} + 5'h01)) == 32'h0000_0000)
		else $error("word extract wider than its field");
	a_illegal_error: assert property (takeBad |-> !mHtrans[1]
		##1 (hresp && !hreadyOut) ##1 (hresp && hreadyOut))
		else $error("illegal access not error terminated");
	a_slave_error: assert property (s_r.phase == dfxd_pkg::ST_EXT_DP1 && mHready && mHresp
		|=> (hresp && !hreadyOut) ##1 (hresp && hreadyOut))
		else $error("slave error not forwarded");
	a_gpio_alias: assert property (takeNorm && haddr[19:12] == 8'hFF
		|-> mHaddr[31:12] == 20'h4000F)
		else $error("gpio page not aliased");
	a_pass_wait: assert property (s_r.phase == dfxd_pkg::ST_IDLE && s_r.passDp
		|-> hreadyOut == mHready && hresp == mHresp)
		else $error("wait state not passed back");
	a_norm_pass: assert property (takeNorm && !haddr[19]
		|-> mHaddr == haddr && mHtrans == htrans)
		else $error("normal access not passed through");
	a_decor_pass: assert property (canTake && reqKind == dfxd_pkg::K_DECOR
		|-> mHaddr == haddr && mHtrans == htrans && mHwrite == hwrite)
		else $error("decorated access not forwarded intact");
	a_cont_upper: assert property (s_r.phase == dfxd_pkg::ST_EXT_DP2
		&& s_r.size != dfxd_pkg::SIZE_WORD |-> ((hrdata >> {s_r.lane, 3'h0})
		& ~(s_r.size == dfxd_pkg::SIZE_BYTE ? dfxd_pkg::MASK_BYTE : dfxd_pkg::MASK_HALF)) == 32'h0)
		else $error("extract result spills past its container");
	a_ext_size: assert property (takeExt |=> s_r.size == $past(hsize))
		else $error("extract container size not captured");
	a_ext_wait: assert property (s_r.phase == dfxd_pkg::ST_EXT_DP1 && !mHready
		|=> s_r.phase == dfxd_pkg::ST_EXT_DP1)
		else $error("extract left the wait state early");

	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	c_ext_done: cover property (takeExt ##2 s_r.phase == dfxd_pkg::ST_EXT_DP2);
	c_ext_wait: cover property (s_r.phase == dfxd_pkg::ST_EXT_DP1 && !mHready);
	c_illegal: cover property (takeBad ##2 s_r.phase == dfxd_pkg::ST_ERR2);
	c_gpio: cover property (takeNorm && haddr[19:12] == 8'hFF);
	c_slave_err: cover property (s_r.phase == dfxd_pkg::ST_EXT_DP1 && mHready && mHresp);
endmodule
`default_nettype wire

// *** dv/dfxd_slave_model.sv ***
// Behavioural peripheral slave space on the bridge's downstream port.
// Assumes the bench sets read value, wait count and error choice per transfer.
`timescale 1ns/1ns
`default_nettype none
module dfxd_slave_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Downstream bus
	input wire logic [31:0] mHaddr,
	input wire logic [1:0] mHtrans,
	input wire logic mHwrite,
	output logic [31:0] mHrdata,
	output logic mHready,
	output logic mHresp,
	// Bench controls and observations
	input wire logic [31:0] rdVal,
	input wire logic [3:0] waitCnt,
	input wire logic errOn,
	output logic [31:0] lastAddr,
	output logic lastWr,
	output int xferCount
);
	logic pend, errPh;
	logic [3:0] cnt;
	always_comb begin
		mHready = !pend || (cnt == 4'h0 && (!errOn || errPh));
		mHresp = pend && cnt == 4'h0 && errOn;
		// Outside a read data phase the bus shows junk, not the last value
		mHrdata = (pend && mHready && !lastWr) ? rdVal : ~rdVal;
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pend <= 1'b0;
			errPh <= 1'b0;
			cnt <= 4'h0;
			lastAddr <= 32'h0;
			lastWr <= 1'b0;
			xferCount <= 0;
		end else begin
			if (pend && cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else if (pend && errOn && !errPh) begin
				errPh <= 1'b1;
			end else begin
				pend <= 1'b0;
				errPh <= 1'b0;
			end
			if (mHready && mHtrans[1]) begin
				pend <= 1'b1;
				cnt <= waitCnt;
				lastAddr <= mHaddr;
				lastWr <= mHwrite;
				xferCount <= xferCount + 1;
			end
		end
	end
endmodule
`default_nettype wire

// *** dv/dfxd_bridge_bench.sv ***
// Self-checking bench for the decorated field extract bridge.
// Assumes the downstream space is the behavioural slave model.
`timescale 1ns/1ns
`default_nettype none
module dfxd_bridge_bench;
	logic sys_clk, resetn, hsel, hwrite, hreadyOut, hresp, mHwrite, mHready, mHresp, errOn, lastWr;
	logic [31:0] haddr, hwdata, hrdata, mHaddr, mHwdata, mHrdata, rdVal, lastAddr;
	logic [1:0] htrans, mHtrans;
	logic [2:0] hsize, mHsize;
	logic [3:0] waitCnt;
	int xferCount;
	int errCount = 0;
	int checksDone = 0;
	int cycles = 0;
	localparam logic [2:0] SZ[5] = '{3'h2, 3'h2, 3'h1, 3'h0, 3'h2};
	localparam logic [4:0] LB[5] = '{5'h04, 5'h00, 5'h0A, 5'h03, 5'h1E};
	localparam logic [3:0] WC[5] = '{4'hF, 4'h0, 4'h9, 4'h7, 4'h7};
	localparam logic [1:0] LN[5] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h0};
	localparam logic [31:0] MA[9] = '{32'h4007_FFFC, 32'h400F_F008, 32'h4008_0000, 32'h400F_EFFC,
		32'h4010_0000, 32'h43FF_FFFC, 32'h4400_4004, 32'h4C0F_F010, 32'h5000_F004};
	localparam logic [31:0] EA[9] = '{32'h4007_FFFC, 32'h4000_F008, 32'h0, 32'h0, 32'h0, 32'h0,
		32'h4400_4004, 32'h4C0F_F010, 32'h5000_F004};

	dfxd_bridge DUT (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hreadyIn(hreadyOut), .hrdata, .hreadyOut, .hresp, .mHaddr, .mHtrans, .mHwrite,
		.mHsize, .mHwdata, .mHrdata, .mHready, .mHresp);
	dfxd_slave_model SLAVE (.sys_clk, .resetn, .mHaddr, .mHtrans, .mHwrite, .mHrdata, .mHready,
		.mHresp, .rdVal, .waitCnt, .errOn, .lastAddr, .lastWr, .xferCount);

	initial begin
		sys_clk = 1'b0;
		forever begin
			#5 sys_clk = ~sys_clk;
		end
	end
	// Whole run needs under a hundred cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errCount++;
			complete_run();
		end
	end

	// ----
	// Helpers
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	function automatic logic [31:0] fx(input logic [31:0] rd, input logic [2:0] sz,
		input logic [1:0] ln, input logic [4:0] b, input logic [3:0] wc);
		logic [31:0] c;
		c = rd >> (8 * ln);
		c = c & (sz == 3'h0 ? dfxd_pkg::MASK_BYTE : sz == 3'h1 ? dfxd_pkg::MASK_HALF : dfxd_pkg::MASK_WORD);
		c = (c >> b) & ((32'h1 << ({28'h0, wc} + 32'h1)) - 32'h1);
		return c << (8 * ln);
	endfunction
	// One transfer; ec < 0 skips the cycle count
	task automatic run(input logic [31:0] a, input logic w, input logic [2:0] sz, input logic [3:0] wt,
		input logic er, input logic [31:0] ea, input logic [31:0] ed, input logic ee, input int ec);
		int n;
		int x0;
		n = 0;
		x0 = xferCount;
		@(posedge sys_clk);
		waitCnt <= wt;
		errOn <= er;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= dfxd_pkg::TRANS_NONSEQ;
		hwrite <= w;
		hsize <= sz;
		@(negedge sys_clk);
		chk(32'(mHsize), 32'(sz));
		chk(32'(mHtrans[1]), 32'(!(ee && !er)));
		@(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= dfxd_pkg::TRANS_IDLE;
		hwdata <= ~a;
		do begin
			@(negedge sys_clk);
			if (n == 0) chk(32'(mHtrans), 32'(dfxd_pkg::TRANS_IDLE));
			if (n == 0 && w) chk(mHwdata, ~a);
			n++;
		end while (hreadyOut !== 1'b1 && n < 20);
		if (ec >= 0) chk(32'(n), 32'(ec));
		chk(32'(hresp), 32'(ee));
		chk(32'(xferCount - x0), (ee && !er) ? 32'h0 : 32'h1);
		if (!(ee && !er)) chk(lastAddr, ea);
		if (!(ee && !er)) chk(32'(lastWr), 32'(w));
		if (!w && !ee) chk(hrdata, ed);
	endtask

	// ----
	// Scenarios
	// ----
	task automatic test_extract();
		logic [31:0] a;
		for (int i = 0; i < 5; i++) begin
			a = {4'h5, LB[i], WC[i], 19'h0F000 | {17'h0, LN[i]}};
			run(a, 1'b0, SZ[i], 4'(i % 2), 1'b0, dfxd_pkg::PERI_BASE | {13'h0, a[18:0]},
				fx(rdVal, SZ[i], LN[i], LB[i], WC[i]), 1'b0, i % 2 + 2);
		end
	endtask
	task automatic test_map();
		logic e;
		for (int i = 0; i < 9; i++) begin
			e = i >= 2 && i <= 5;
			run(MA[i], i >= 7, dfxd_pkg::SIZE_WORD, 4'(i % 3), 1'b0, EA[i], rdVal, e,
				e ? 2 : i % 3 + 1);
		end
	endtask
	task automatic test_errors();
		run(32'h5020_F008, 1'b0, dfxd_pkg::SIZE_WORD, 4'h1, 1'b1, 32'h4000_F008, 32'h0, 1'b1, 5);
		run(32'h4000_1000, 1'b0, dfxd_pkg::SIZE_WORD, 4'h2, 1'b1, 32'h4000_1000, 32'h0, 1'b1, 4);
	endtask
	task automatic test_reset();
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= 32'h5008_0100;
		htrans <= dfxd_pkg::TRANS_NONSEQ;
		hwrite <= 1'b0;
		@(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= dfxd_pkg::TRANS_IDLE;
		resetn <= 1'b0;
		@(negedge sys_clk);
		chk(32'(hreadyOut), 32'h1);
		chk(32'(hresp), 32'h0);
		chk(32'(mHtrans), 32'(dfxd_pkg::TRANS_IDLE));
		@(posedge sys_clk);
		resetn <= 1'b1;
	endtask

	initial begin
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = dfxd_pkg::TRANS_IDLE;
		hwrite = 1'b0;
		hsize = dfxd_pkg::SIZE_WORD;
		hwdata = 32'h0;
		rdVal = 32'hC3A5_9E6B;
		waitCnt = 4'h0;
		errOn = 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		test_extract();
		test_map();
		test_errors();
		test_reset();
		test_extract();
		complete_run();
	end
endmodule
`default_nettype wire
